/* cwu_defines.svh */
`ifndef CWU_DEFINES_SVH
`define CWU_DEFINES_SVH

`define CWU_WORD_W      32
`define CWU_CNT_RESET   32'h0000_0000
`define CWU_CNT_STEP    32'h0000_0001
`define CWU_WORD_ZERO   32'h0000_0000
`define CWU_PORT_A      1'h0
`define CWU_PORT_B      1'h1

`endif

/* cwu_pkg.sv */
`default_nettype none
package cwu_pkg;
	typedef enum logic [1:0] {
		CWU_IDLE,
		CWU_WAIT_CNT,
		CWU_WAIT_PIN
	} cwu_state_t;

	typedef struct packed {
		cwu_state_t  state;
		logic [31:0] target;
		logic [31:0] mask;
		logic        port_sel;
	} cwu_regs_t;
endpackage : cwu_pkg
`default_nettype wire

/* cwu_sys_counter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cwu_defines.svh"

module cwu_sys_counter #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// shared counter value
	output logic [WIDTH-1:0]      sys_count
);
	// refuse widths the shared compare path cannot serve
	if (WIDTH != `CWU_WORD_W) begin : g_width_check
		$error("cwu_sys_counter: WIDTH must be 32");
	end

	// free-running counter, wraps naturally
	always_ff @(posedge mclk) begin
		if (rst) begin
			sys_count <= `CWU_CNT_RESET;
		end else begin
			sys_count <= sys_count + `CWU_CNT_STEP;
		end
	end

	a_count_steps: assert property (@(posedge mclk) disable iff (rst)
		!$past(rst) |-> sys_count == $past(sys_count) + `CWU_CNT_STEP)
		else $error("system counter did not advance by one");
endmodule : cwu_sys_counter
`default_nettype wire

/* cwu_wait_unit.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cwu_defines.svh"

module cwu_wait_unit #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// wait commands from the core
	input  wire logic             cnt_wait_req,
	input  wire logic             pin_wait_req,
	input  wire logic [WIDTH-1:0] wait_value,
	input  wire logic [WIDTH-1:0] wait_mask,
	input  wire logic             wait_port,
	// stall back to the core
	output logic                  stall,
	output logic                  wait_done,
	// port inputs
	input  wire logic [WIDTH-1:0] port_a_inputs,
	input  wire logic [WIDTH-1:0] port_b_inputs,
	// shared counter, observable
	output logic [WIDTH-1:0]      sys_count
);
	cwu_pkg::cwu_regs_t r;
	cwu_pkg::cwu_regs_t next_r;
	logic               cnt_hit;
	logic               pin_hit;
	logic [WIDTH-1:0]   port_in;

	// refuse widths the 32-bit compare logic cannot serve
	if (WIDTH != `CWU_WORD_W) begin : g_width_check
		$error("cwu_wait_unit: WIDTH must be 32");
	end

	// masked equality used by the pin wait
	function automatic logic masked_eq(input logic [31:0] pins, input logic [31:0] msk,
		input logic [31:0] pat);
		masked_eq = ((pins & msk) == pat);
	endfunction : masked_eq

	// input register chosen by the one-bit port operand
	function automatic logic [31:0] pick_port(input logic sel, input logic [31:0] pa,
		input logic [31:0] pb);
		pick_port = (sel == `CWU_PORT_B) ? pb : pa;
	endfunction : pick_port

	cwu_sys_counter #(.WIDTH(WIDTH)) u_counter (
		.mclk      (mclk),
		.rst       (rst),
		.sys_count (sys_count)
	);

	// port selection; port B inputs when port_sel is 1, port A inputs otherwise
	assign port_in = pick_port(r.port_sel, port_a_inputs, port_b_inputs);
	// comparators run every cycle
	assign cnt_hit = (sys_count == r.target);
	assign pin_hit = masked_eq(port_in, r.mask, r.target);

	// next state
	always_comb begin
		next_r = r;
		case (r.state)
			cwu_pkg::CWU_IDLE: begin
				if (cnt_wait_req) begin
					next_r.state  = cwu_pkg::CWU_WAIT_CNT;
					next_r.target = wait_value;
				end else if (pin_wait_req) begin
					next_r.state    = cwu_pkg::CWU_WAIT_PIN;
					next_r.target   = wait_value;
					next_r.mask     = wait_mask;
					next_r.port_sel = wait_port;
				end
			end
			cwu_pkg::CWU_WAIT_CNT: begin
				if (cnt_hit) next_r.state = cwu_pkg::CWU_IDLE;
			end
			cwu_pkg::CWU_WAIT_PIN: begin
				if (pin_hit) next_r.state = cwu_pkg::CWU_IDLE;
			end
			default: next_r.state = cwu_pkg::CWU_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge mclk) begin
		if (rst) begin
			r.state    <= cwu_pkg::CWU_IDLE;
			r.target   <= `CWU_WORD_ZERO;
			r.mask     <= `CWU_WORD_ZERO;
			r.port_sel <= `CWU_PORT_A;
		end else begin
			r <= next_r;
		end
	end

	// stall held while waiting and not yet matched
	assign stall = (r.state == cwu_pkg::CWU_WAIT_CNT && !cnt_hit)
		|| (r.state == cwu_pkg::CWU_WAIT_PIN && !pin_hit);
	assign wait_done = (r.state == cwu_pkg::CWU_WAIT_CNT && cnt_hit)
		|| (r.state == cwu_pkg::CWU_WAIT_PIN && pin_hit);

	// request steps seen from the idle state, and the busy state
	sequence s_cnt_start;
		r.state == cwu_pkg::CWU_IDLE && cnt_wait_req;
	endsequence
	sequence s_pin_start;
		r.state == cwu_pkg::CWU_IDLE && !cnt_wait_req && pin_wait_req;
	endsequence
	sequence s_both_req;
		r.state == cwu_pkg::CWU_IDLE && cnt_wait_req && pin_wait_req;
	endsequence
	sequence s_busy;
		r.state != cwu_pkg::CWU_IDLE;
	endsequence

	// counter wait stalls from the first cycle after it is taken
	a_cnt_stalls: assert property (@(posedge mclk) disable iff (rst)
		s_cnt_start ##1 (sys_count != $past(wait_value)) |-> stall)
		else $error("counter wait did not stall");

	// counter match releases in the very cycle it is seen
	a_cnt_release: assert property (@(posedge mclk) disable iff (rst)
		(r.state == cwu_pkg::CWU_WAIT_CNT && sys_count == r.target) |-> !stall && wait_done)
		else $error("counter match not released same cycle");

	// only exact equality ends a counter wait
	a_cnt_equal_only: assert property (@(posedge mclk) disable iff (rst)
		wait_done && r.state == cwu_pkg::CWU_WAIT_CNT |-> sys_count == r.target)
		else $error("counter wait ended without equality");

	// pin wait stalls while the masked inputs differ
	a_pin_stalls: assert property (@(posedge mclk) disable iff (rst)
		s_pin_start ##1 !masked_eq(port_in, $past(wait_mask), $past(wait_value)) |-> stall)
		else $error("pin wait did not stall");

	// masked-off pins never keep the wait going
	a_pin_mask: assert property (@(posedge mclk) disable iff (rst)
		r.state == cwu_pkg::CWU_WAIT_PIN && ((port_in & r.mask) == r.target) |-> wait_done)
		else $error("masked pin match missed");

	// the port given with the request is the one watched
	a_port_select: assert property (@(posedge mclk) disable iff (rst)
		s_pin_start ##1 1'b1 |-> port_in == ($past(wait_port) ? port_b_inputs : port_a_inputs))
		else $error("wrong port watched");

	// a stalled pin wait really sees a mismatch
	a_pin_every: assert property (@(posedge mclk) disable iff (rst)
		r.state == cwu_pkg::CWU_WAIT_PIN && stall |-> (port_in & r.mask) != r.target)
		else $error("pin wait stalled on a match");

	// after a match the unit is idle and the core runs
	a_resume_next: assert property (@(posedge mclk) disable iff (rst)
		wait_done |=> r.state == cwu_pkg::CWU_IDLE && !stall)
		else $error("unit did not return to idle after match");

	// idle unit neither stalls nor reports a match
	a_idle_quiet: assert property (@(posedge mclk) disable iff (rst)
		r.state == cwu_pkg::CWU_IDLE |-> !stall && !wait_done)
		else $error("idle unit stalled or matched");

	// stall and match are never shown together
	a_stall_done_excl: assert property (@(posedge mclk) disable iff (rst)
		!(stall && wait_done))
		else $error("stall and match raised together");

	// a match lasts a single cycle
	a_done_pulse: assert property (@(posedge mclk) disable iff (rst)
		wait_done |=> !wait_done)
		else $error("match held for more than one cycle");

	// counter request wins over a pin request in the same cycle
	a_cnt_priority: assert property (@(posedge mclk) disable iff (rst)
		s_both_req |=> r.state == cwu_pkg::CWU_WAIT_CNT)
		else $error("counter request lost priority");

	// counter target captured with the request
	a_cnt_operand: assert property (@(posedge mclk) disable iff (rst)
		s_cnt_start |=> r.target == $past(wait_value))
		else $error("counter target not captured");

	// pattern and mask captured with the request
	a_pin_operand: assert property (@(posedge mclk) disable iff (rst)
		s_pin_start |=> r.target == $past(wait_value) && r.mask == $past(wait_mask))
		else $error("pin operands not captured");

	// port choice captured with the request
	a_port_latched: assert property (@(posedge mclk) disable iff (rst)
		s_pin_start |=> r.port_sel == $past(wait_port))
		else $error("port choice not captured");

	// operands stay put while a wait runs, requests are ignored
	a_busy_holds: assert property (@(posedge mclk) disable iff (rst)
		s_busy |=> $stable(r.target) && $stable(r.mask) && $stable(r.port_sel))
		else $error("operands changed during a wait");

	// an unmatched counter wait keeps waiting
	a_cnt_stays: assert property (@(posedge mclk) disable iff (rst)
		r.state == cwu_pkg::CWU_WAIT_CNT && !cnt_hit |=> r.state == cwu_pkg::CWU_WAIT_CNT)
		else $error("counter wait left without a match");

	// an unmatched pin wait keeps checking the inputs
	a_pin_stays: assert property (@(posedge mclk) disable iff (rst)
		r.state == cwu_pkg::CWU_WAIT_PIN && !pin_hit |=> r.state == cwu_pkg::CWU_WAIT_PIN)
		else $error("pin wait left without a match");

	// unmatched counter wait shows stall and no match
	a_cnt_waiting: assert property (@(posedge mclk) disable iff (rst)
		r.state == cwu_pkg::CWU_WAIT_CNT && !cnt_hit |-> stall && !wait_done)
		else $error("counter wait not stalling");

	// a matching pin wait releases at once
	a_pin_release: assert property (@(posedge mclk) disable iff (rst)
		r.state == cwu_pkg::CWU_WAIT_PIN && pin_hit |-> wait_done && !stall)
		else $error("pin match not released same cycle");

	// an all-zero mask and pattern match whatever the pins show
	a_mask_zero: assert property (@(posedge mclk) disable iff (rst)
		r.state == cwu_pkg::CWU_WAIT_PIN && r.mask == `CWU_WORD_ZERO
		&& r.target == `CWU_WORD_ZERO |-> wait_done)
		else $error("fully masked pin wait did not match");

	// without a request the unit stays idle
	a_idle_stays: assert property (@(posedge mclk) disable iff (rst)
		r.state == cwu_pkg::CWU_IDLE && !cnt_wait_req && !pin_wait_req
		|=> r.state == cwu_pkg::CWU_IDLE)
		else $error("unit left idle without a request");
endmodule : cwu_wait_unit
`default_nettype wire

/* cwu_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// core side: one-edge wait requests, operands scrambled once released
module cwu_core_model (
	// clock
	input  wire logic        mclk,
	// wait commands
	output var  logic        cnt_wait_req,
	output var  logic        pin_wait_req,
	output var  logic [31:0] wait_value,
	output var  logic [31:0] wait_mask,
	output var  logic        wait_port
);
	// idle at time zero
	initial begin
		{cnt_wait_req, pin_wait_req, wait_port, wait_value, wait_mask} = 67'h0;
	end
	// counter wait request
	task automatic issue_cnt(input logic [31:0] t);
		cnt_wait_req <= 1'h1;
		wait_value   <= t;
		@(posedge mclk);
		cnt_wait_req <= 1'h0;
		wait_value   <= ~t;
	endtask : issue_cnt
	// pin wait request with a full word pattern
	task automatic issue_pin(input logic [31:0] v, input logic [31:0] m, input logic p);
		pin_wait_req <= 1'h1;
		{wait_value, wait_mask, wait_port} <= {v, m, p};
		@(posedge mclk);
		pin_wait_req <= 1'h0;
		{wait_value, wait_mask, wait_port} <= ~{v, m, p};
	endtask : issue_pin
endmodule : cwu_core_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        mclk = 1'h0, rst = 1'h1;
	logic        cnt_wait_req, pin_wait_req, wait_port, stall, wait_done;
	logic [31:0] wait_value, wait_mask, sys_count, r, m, v, exp_cnt = 32'h0;
	logic [31:0] port_a_inputs = 32'h0, port_b_inputs = 32'h0, seed = 32'h4E75D0C4;
	logic [31:0] q[$];
	int          fail_count = 0, total_checks = 0;
	cwu_core_model i_cwu_core_model (.mclk, .cnt_wait_req, .pin_wait_req, .wait_value,
		.wait_mask, .wait_port);
	cwu_wait_unit i_cwu_wait_unit (.mclk, .rst, .cnt_wait_req, .pin_wait_req, .wait_value,
		.wait_mask, .wait_port, .stall, .wait_done, .port_a_inputs, .port_b_inputs, .sys_count);
	initial forever #4 mclk = ~mclk;
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic await_done();
		repeat (300) begin
			@(posedge mclk);
			if (wait_done === 1'h1) break;
		end
	endtask : await_done
	// watched port gets w, the other port o
	task automatic drive(input logic p, input logic [31:0] w, input logic [31:0] o);
		port_a_inputs <= p ? o : w;
		port_b_inputs <= p ? w : o;
	endtask : drive
	// counter model and oldest note against each completion
	always @(posedge mclk) begin
		if (rst !== 1'h1) check("sys_count", sys_count, exp_cnt);
		exp_cnt <= (rst === 1'h1) ? 32'h0 : exp_cnt + 32'h1;
		if (wait_done === 1'h1) begin
			check("done_count", sys_count, q.size() ? q.pop_front() : ~sys_count);
			check("stall_done", {31'h0, stall}, 32'h0);
		end
	end
	// hang guard
	initial begin
		repeat (3000) @(posedge mclk);
		fail_count++;
		results();
	end
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'h0;
		@(posedge mclk);
		// back-to-back counter waits, nearest target first
		for (int i = 0; i < 6; i++) begin
			v = exp_cnt + 32'h2 + (i > 0 ? rnd() % 32'h10 : 32'h0);
			q.push_back(v);
			i_cwu_core_model.issue_cnt(v);
			await_done();
		end
		$display("counter waits finished");
		// pin waits on both ports, only masked bits of the watched port count
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			m = rnd() | 32'h1;
			v = r & m;
			drive(i[0], v ^ 32'h1, v);
			i_cwu_core_model.issue_pin(v, m, i[0]);
			repeat (3) @(posedge mclk);
			check("stall_pin", {31'h0, stall}, 32'h1);
			drive(i[0], v | (~m & rnd()), v ^ 32'h1);
			q.push_back(exp_cnt + 32'h1);
			await_done();
		end
		$display("pin waits finished");
		// passed target keeps stalling; a request meanwhile is ignored
		i_cwu_core_model.issue_cnt(exp_cnt);
		i_cwu_core_model.issue_pin(32'h0, 32'h0, 1'h0);
		repeat (40) @(posedge mclk);
		check("stall_passed", {31'h0, stall}, 32'h1);
		rst <= 1'h1;
		repeat (2) @(posedge mclk);
		check("stall_reset", {31'h0, stall}, 32'h0);
		check("notes_left", q.size(), 32'h0);
		$display("passed target finished");
		results();
	end
endmodule : tb
`default_nettype wire
